// [ibm_sync.sv]
`timescale 1ns/10ps
package ibm_pkg;
	localparam int unsigned IBM_ADDR_W       = 15;
	localparam int unsigned IBM_MEM_DEPTH    = 32768;
	localparam int unsigned IBM_SEL_W        = 3;
	localparam int unsigned IBM_TYPE_W       = 4;
	localparam int unsigned IBM_REF_CLK_HZ   = 20000000;
	localparam int unsigned IBM_SCL_MAX_HZ   = 1000000;
	localparam int unsigned IBM_MIN_OVERSAMP = 16;
	localparam int unsigned IBM_PIN_W        = 6;
	localparam logic [5:0]  IBM_PIN_RST      = 6'h03;
	localparam int unsigned IBM_PIN_SCL      = 0;
	localparam int unsigned IBM_PIN_SDA      = 1;
	localparam int unsigned IBM_PIN_WP       = 2;
	localparam int unsigned IBM_PIN_SEL      = 3;
	localparam logic [3:0]  IBM_BYTE_BITS    = 4'h8;
	localparam int unsigned IBM_RW_BIT       = 0;

	typedef enum logic [2:0] {
		IBM_IDLE,
		IBM_DEV,
		IBM_ADDR_HI,
		IBM_ADDR_LO,
		IBM_WDATA,
		IBM_RDATA
	} ibm_state_t;

	typedef struct packed {
		ibm_state_t            state;
		logic [3:0]            bitcnt;
		logic [7:0]            shreg;
		logic [IBM_ADDR_W-1:0] addr;
		logic                  ack;
		logic                  nack;
		logic                  oe;
		logic                  scl_p;
		logic                  sda_p;
	} ibm_st_t;
endpackage

module ibm_sync #(
	parameter int unsigned W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	// The first stage feeds only the second one.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_reg <= RST;
			q_o      <= RST;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule

// [ibm_i2c_mem_slave.sv]
// Behaviour
// - Array of 32768 bytes, byte addressed.
// - Answer only when select pins match address.
// - Unconnected select pins read as low.
// - Sample on SCL rise, change after fall.
// - SDA is open drain: pull low or release.
// - Protect pin high blocks all array writes.
// - Protect pin low allows writes; defaults low.
// - Commit each byte right after its reception.
// - No busy state; next transfer may follow.
// - Works with SCL up to 1 MHz.
// - Behaves like a standard serial byte memory.
// - Slave byte: type, select, direction in bit0.
// - Two address bytes; top bit ignored.
// - Address increments per byte, wraps to zero.
// - Read continues while master acknowledges.
`timescale 1ns/10ps
module ibm_i2c_mem_slave
	import ibm_pkg::*;
#(
	parameter int unsigned           ADDR_W   = ibm_pkg::IBM_ADDR_W,
	parameter int unsigned           DEPTH    = ibm_pkg::IBM_MEM_DEPTH,
	parameter int unsigned           CLK_HZ   = ibm_pkg::IBM_REF_CLK_HZ,
	parameter int unsigned           SCL_HZ   = ibm_pkg::IBM_SCL_MAX_HZ,
	// Arbitrary device type code.
	parameter logic [ibm_pkg::IBM_TYPE_W-1:0] DEV_TYPE = 4'h5
) (
	input  wire logic                          ref_clk_i,
	input  wire logic                          rstn_i,
	input  wire logic                          scl_i,
	input  wire logic                          sda_i,
	output logic                               sda_o,
	output logic                               sda_oe_o,
	input  wire logic [ibm_pkg::IBM_SEL_W-1:0] device_select_pins_i,
	input  wire logic                          wp_i
);
	import ibm_pkg::*;

	generate
		if (ADDR_W != IBM_ADDR_W || DEPTH != (1 << ADDR_W)) begin : g_bad_depth
			$error("Array depth must match the fifteen bit address.");
		end
		if (CLK_HZ < SCL_HZ * IBM_MIN_OVERSAMP) begin : g_bad_rate
			$error("Reference clock too slow to oversample the serial clock.");
		end
	endgenerate

	ibm_st_t                   st_reg;
	ibm_st_t                   st_next;
	logic [IBM_PIN_W-1:0]      pins_s;
	logic                      scl_s;
	logic                      sda_s;
	logic                      wp_s;
	logic [IBM_SEL_W-1:0]      sel_s;
	logic                      rise;
	logic                      fall;
	logic                      start_c;
	logic                      stop_c;
	logic                      mem_we;
	logic [7:0]                mem_q;
	logic [7:0]                mem [0:DEPTH-1];

	function automatic logic [IBM_ADDR_W-1:0] addr_inc(input logic [IBM_ADDR_W-1:0] a);
		addr_inc = a + 1'b1;
	endfunction

	function automatic logic dev_hit(input logic [7:0] b, input logic [IBM_SEL_W-1:0] sel);
		dev_hit = (b[7:4] == DEV_TYPE) && (b[3:1] == sel);
	endfunction

	// Pins are oversampled; the serial clock is far slower than the reference clock.
	ibm_sync #(
		.W   (IBM_PIN_W),
		.RST (IBM_PIN_RST)
	) u_sync (
		.clk_i  (ref_clk_i),
		.rstn_i (rstn_i),
		.d_i    ({device_select_pins_i, wp_i, sda_i, scl_i}),
		.q_o    (pins_s)
	);

	assign scl_s = pins_s[IBM_PIN_SCL];
	assign sda_s = pins_s[IBM_PIN_SDA];
	assign wp_s  = pins_s[IBM_PIN_WP];
	// Unconnected select pins read low through the pad pull-down.
	assign sel_s = pins_s[IBM_PIN_SEL +: IBM_SEL_W];

	assign rise    = scl_s & ~st_reg.scl_p;
	assign fall    = ~scl_s & st_reg.scl_p;
	assign start_c = scl_s & st_reg.scl_p & st_reg.sda_p & ~sda_s;
	assign stop_c  = scl_s & st_reg.scl_p & ~st_reg.sda_p & sda_s;

	always_comb begin
		st_next = st_reg;
		mem_we  = 1'b0;
		if (start_c) begin
			st_next.state  = IBM_DEV;
			st_next.bitcnt = '0;
			st_next.ack    = 1'b0;
			st_next.oe     = 1'b0;
		end else if (stop_c) begin
			st_next.state = IBM_IDLE;
			st_next.ack   = 1'b0;
			st_next.oe    = 1'b0;
		end else begin
			case (st_reg.state)
				IBM_IDLE: begin
					st_next.oe = 1'b0;
				end
				IBM_DEV, IBM_ADDR_HI, IBM_ADDR_LO, IBM_WDATA: begin
					if (rise && !st_reg.ack) begin
						st_next.shreg  = {st_reg.shreg[6:0], sda_s};
						st_next.bitcnt = st_reg.bitcnt + 4'h1;
					end else if (fall && !st_reg.ack && st_reg.bitcnt == IBM_BYTE_BITS) begin
						st_next.ack = 1'b1;
						st_next.oe  = 1'b1;
						case (st_reg.state)
							IBM_DEV: begin
								if (!dev_hit(st_reg.shreg, sel_s)) begin
									st_next.state = IBM_IDLE;
									st_next.ack   = 1'b0;
									st_next.oe    = 1'b0;
								end
							end
							IBM_ADDR_HI: begin
								st_next.addr[IBM_ADDR_W-1:8] = st_reg.shreg[6:0];
							end
							IBM_ADDR_LO: begin
								st_next.addr[7:0] = st_reg.shreg;
							end
							IBM_WDATA: begin
								// Protected bytes are still acknowledged and counted.
								mem_we       = ~wp_s;
								st_next.addr = addr_inc(st_reg.addr);
							end
							default: begin
								st_next.state = IBM_IDLE;
							end
						endcase
					end else if (fall && st_reg.ack) begin
						st_next.ack    = 1'b0;
						st_next.oe     = 1'b0;
						st_next.bitcnt = '0;
						case (st_reg.state)
							IBM_DEV: begin
								if (st_reg.shreg[IBM_RW_BIT]) begin
									st_next.state = IBM_RDATA;
									st_next.shreg = mem_q;
									st_next.oe    = ~mem_q[7];
								end else begin
									st_next.state = IBM_ADDR_HI;
								end
							end
							IBM_ADDR_HI: begin
								st_next.state = IBM_ADDR_LO;
							end
							default: begin
								st_next.state = IBM_WDATA;
							end
						endcase
					end
				end
				IBM_RDATA: begin
					if (rise && !st_reg.ack) begin
						st_next.bitcnt = st_reg.bitcnt + 4'h1;
					end else if (rise && st_reg.ack) begin
						st_next.nack = sda_s;
					end else if (fall && !st_reg.ack) begin
						if (st_reg.bitcnt == IBM_BYTE_BITS) begin
							st_next.oe   = 1'b0;
							st_next.ack  = 1'b1;
							st_next.addr = addr_inc(st_reg.addr);
						end else begin
							st_next.shreg = {st_reg.shreg[6:0], 1'b0};
							st_next.oe    = ~st_reg.shreg[6];
						end
					end else if (fall && st_reg.ack) begin
						st_next.ack = 1'b0;
						if (!st_reg.nack) begin
							st_next.shreg  = mem_q;
							st_next.oe     = ~mem_q[7];
							st_next.bitcnt = '0;
						end else begin
							st_next.state = IBM_IDLE;
							st_next.oe    = 1'b0;
						end
					end
				end
				default: begin
					st_next.state = IBM_IDLE;
					st_next.oe    = 1'b0;
				end
			endcase
		end
		st_next.scl_p = scl_s;
		st_next.sda_p = sda_s;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg <= '{state: IBM_IDLE, bitcnt: 4'h0, shreg: 8'h00, addr: '0,
				ack: 1'b0, nack: 1'b1, oe: 1'b0, scl_p: 1'b1, sda_p: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end

	// The read word is fetched one serial bit ahead, so a whole bit time covers the lookup.
	always_ff @(posedge ref_clk_i) begin
		if (mem_we) begin
			mem[st_reg.addr] <= st_reg.shreg;
		end
		mem_q <= mem[st_reg.addr];
	end

	// The pad only ever pulls low; the pull-up makes the high level.
	assign sda_o    = 1'b0;
	assign sda_oe_o = st_reg.oe;
endmodule

// [ibm_i2c_mem_slave_sva.sv]
`timescale 1ns/10ps
module ibm_i2c_mem_slave_sva (
	input logic ref_clk_i,
	input logic rstn_i,
	input logic scl_i,
	input logic sda_i,
	input logic sda_o,
	input logic sda_oe_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_bit; ##[1:40] $rose(scl_i) ##[1:40] $fell(scl_i); endsequence
	property p_od; !sda_o; endproperty
	property p_on; $rose(sda_oe_o) |-> !$past(scl_i, 2); endproperty
	property p_off; $fell(sda_oe_o) |-> !$past(scl_i, 2); endproperty
	property p_hold; scl_i && $past(scl_i, 5) |-> $stable(sda_oe_o); endproperty
	property p_span; $rose(sda_oe_o) |-> sda_oe_o throughout s_bit; endproperty
	property p_stop; scl_i && $rose(sda_i) |-> !sda_oe_o [*8]; endproperty
	property p_start; scl_i && $fell(sda_i) |=> !sda_oe_o [*8]; endproperty
	property p_rst; $rose(rstn_i) |-> !sda_oe_o [*4]; endproperty
	a_od: assert property (p_od) else $error("sda_o high");
	a_on: assert property (p_on) else $error("oe rise");
	a_off: assert property (p_off) else $error("oe fall");
	a_hold: assert property (p_hold) else $error("oe moved");
	a_span: assert property (p_span) else $error("oe short");
	a_stop: assert property (p_stop) else $error("oe at stop");
	a_start: assert property (p_start) else $error("oe at start");
	a_rst: assert property (p_rst) else $error("oe at reset");
endmodule
bind ibm_i2c_mem_slave ibm_i2c_mem_slave_sva u_sva (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

// [ibm_mst.sv]
`timescale 1ns/10ps
module ibm_mst (
	input  logic link_clk_i,
	input  logic sda_i,
	output logic scl_o,
	output logic sda_pull_o
);
	initial scl_o = 1'b1;
	initial sda_pull_o = 1'b0;
	// Halves of 9 and 8 link clocks keep SCL just under 1 MHz.
	task automatic frame(input logic s);
		@(posedge link_clk_i);
		sda_pull_o = !s;
		repeat (8) @(posedge link_clk_i);
		scl_o = 1'b1;
		repeat (8) @(posedge link_clk_i);
		sda_pull_o = s;
		repeat (8) @(posedge link_clk_i);
		scl_o = !s;
	endtask
	task automatic xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			@(posedge link_clk_i);
			sda_pull_o = !d[i];
			repeat (8) @(posedge link_clk_i);
			scl_o = 1'b1;
			repeat (8) @(posedge link_clk_i);
			r[i] = sda_i;
			scl_o = 1'b0;
		end
	endtask
endmodule

// [ibm_i2c_mem_slave_bench.sv]
`timescale 1ns/10ps
module ibm_i2c_mem_slave_bench;
	localparam logic [3:0] DT = 4'h5;
	logic       ref_clk = 1'b0, link_clk = 1'b0, rstn = 1'b0, wp = 1'b0;
	logic       scl, pull, oe;
	logic [2:0] sel = 3'h5;
	logic [8:0] rr;
	int         fails = 0, cmp_count = 0;
	// Pull-up on SDA: low whenever either side pulls.
	wire        sda = !(oe || pull);
	ibm_i2c_mem_slave #(.DEV_TYPE(DT)) u_ibm_i2c_mem_slave (.ref_clk_i(ref_clk), .rstn_i(rstn),
		.scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe), .device_select_pins_i(sel),
		.wp_i(wp));
	ibm_mst u_ibm_mst (.link_clk_i(link_clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
	initial forever #25 ref_clk = !ref_clk;
	initial #7 forever #32 link_clk = !link_clk;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		if (fails == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic tx(input logic [7:0] d, input logic n, input logic ea);
		u_ibm_mst.xfer({d, n}, rr);
		chk({7'h0, rr[0]}, {7'h0, ea});
	endtask
	task automatic go();
		u_ibm_mst.frame(1'b1);
		tx({DT, 3'h5, 1'b0}, 1'b1, 1'b0);
		tx(8'hff, 1'b1, 1'b0);
		tx(8'hff, 1'b1, 1'b0);
	endtask
	task automatic rd2(input logic [7:0] e0, input logic [7:0] e1);
		go();
		u_ibm_mst.frame(1'b1);
		tx({DT, 3'h5, 1'b1}, 1'b1, 1'b0);
		tx(8'hff, 1'b0, 1'b0);
		chk(rr[8:1], e0);
		tx(8'hff, 1'b1, 1'b1);
		chk(rr[8:1], e1);
		u_ibm_mst.frame(1'b0);
	endtask
	task automatic t_write();
		go();
		tx(8'h3c, 1'b1, 1'b0);
		tx(8'ha5, 1'b1, 1'b0);
		u_ibm_mst.frame(1'b0);
		rd2(8'h3c, 8'ha5);
	endtask
	task automatic t_protect();
		@(posedge ref_clk) #1 wp = 1'b1;
		go();
		tx(8'h00, 1'b1, 1'b0);
		u_ibm_mst.frame(1'b0);
		@(posedge ref_clk) #1 wp = 1'b0;
		rd2(8'h3c, 8'ha5);
	endtask
	task automatic t_select();
		u_ibm_mst.frame(1'b1);
		tx({DT, 3'h2, 1'b0}, 1'b1, 1'b1);
		u_ibm_mst.frame(1'b0);
		u_ibm_mst.frame(1'b1);
		tx({4'h3, 3'h5, 1'b0}, 1'b1, 1'b1);
		u_ibm_mst.frame(1'b0);
		// Moving the select pins must move the address the part answers to.
		@(posedge ref_clk) #1 sel = 3'h2;
		u_ibm_mst.frame(1'b1);
		tx({DT, 3'h2, 1'b0}, 1'b1, 1'b0);
		u_ibm_mst.frame(1'b0);
		u_ibm_mst.frame(1'b1);
		tx({DT, 3'h5, 1'b0}, 1'b1, 1'b1);
		u_ibm_mst.frame(1'b0);
		@(posedge ref_clk) #1 sel = 3'h5;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		#1 rstn = 1'b1;
		t_write();
		t_protect();
		t_select();
		close_out();
	end
endmodule
